//--- hdl/pll_clock_pkg.sv
// Summary of operation
// - after system reset the synthesizer is held in reset, disabled, all control fields zero
// - bit 15 low holds synthesizer reset, high releases; bit 14 disables or enables
// - bit 13 low passes the input clock to the output; high passes the synthesized clock
// - synthesizer input is the active oscillator, internal or external, chosen by the oscillator_select input
// - output equals input, halved by bit 8, times M, divided by N from the table
// - code in bits 7..4 picks M 4..18 step 2, then 20,24,26,34; 1100..1111 unavailable
package pll_clock_pkg;

   // register map
   localparam logic [31:0] PLL_CONTROL_ADDR = 32'h4000_0060;
   localparam logic [15:0] PLL_CONTROL_RESET = 16'h0000;
   // bits software may write; bit 12 and reserved bits are excluded
   localparam logic [15:0] PLL_CONTROL_WRITE_MASK = 16'he1f7;

   // field positions
   localparam int RELEASE_BIT = 15;
   localparam int ENABLE_BIT = 14;
   localparam int OUTPUT_SELECT_BIT = 13;
   localparam int LOCKED_BIT = 12;
   localparam int HALVER_BIT = 8;
   localparam int FEEDBACK_LSB = 4;
   localparam int DIVIDER_LSB = 0;

   // decoded ratio after reset (code 0000 and 000)
   localparam logic [5:0] RESET_MULTIPLIER = 6'h04;
   localparam logic [4:0] RESET_DIVIDER = 5'h01;

   // settling time before the lock flag rises
   localparam int CLOCK_PERIOD_NS = 10;
   localparam int LOCK_TIME_NS = 100000;
   localparam int LOCK_CYCLES = (LOCK_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

   // AHB transfer types
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic reset_release;
      logic enable;
      logic output_select;
      logic synth_locked;
      logic [2:0] spare_hi;
      logic input_halver;
      logic [3:0] feedback_multiplier_code;
      logic spare_lo;
      logic [2:0] output_divider_code;
   } pll_control_t;

   typedef enum logic [2:0] {
      SYNTH_OFF = 3'b001,
      SYNTH_SETTLING = 3'b010,
      SYNTH_LOCKED = 3'b100
   } synth_state_t;

   function automatic logic [5:0] multiplier_of(input logic [3:0] code);
      case (code)
         4'h0: multiplier_of = 6'h04;
         4'h1: multiplier_of = 6'h06;
         4'h2: multiplier_of = 6'h08;
         4'h3: multiplier_of = 6'h0a;
         4'h4: multiplier_of = 6'h0c;
         4'h5: multiplier_of = 6'h0e;
         4'h6: multiplier_of = 6'h10;
         4'h7: multiplier_of = 6'h12;
         4'h8: multiplier_of = 6'h14;
         4'h9: multiplier_of = 6'h18;
         4'ha: multiplier_of = 6'h1a;
         4'hb: multiplier_of = 6'h22;
         default: multiplier_of = 6'h00;
      endcase
   endfunction

   function automatic logic code_available(input logic [3:0] code);
      code_available = ~(code[3] & code[2]);
   endfunction

   function automatic logic [4:0] divider_of(input logic [2:0] code);
      case (code)
         3'h0: divider_of = 5'h01;
         3'h1: divider_of = 5'h02;
         3'h2: divider_of = 5'h03;
         3'h3: divider_of = 5'h04;
         3'h4: divider_of = 5'h06;
         3'h5: divider_of = 5'h08;
         3'h6: divider_of = 5'h03;
         3'h7: divider_of = 5'h10;
         default: divider_of = 5'h01;
      endcase
   endfunction

endpackage

//--- hdl/synth_ratio_decode.sv
module synth_ratio_decode
   import pll_clock_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // register contents
   input pll_control_t ctrl,
   // decoded ratio for the analog core
   output logic core_predivide,
   output logic [5:0] core_multiplier,
   output logic [4:0] core_divider,
   output logic code_valid
);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         core_predivide <= 1'b0;
      end else begin
         core_predivide <= ctrl.input_halver;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         core_multiplier <= RESET_MULTIPLIER;
         code_valid <= 1'b1;
      end else begin
         core_multiplier <= multiplier_of(ctrl.feedback_multiplier_code);
         code_valid <= code_available(ctrl.feedback_multiplier_code);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         core_divider <= RESET_DIVIDER;
      end else begin
         core_divider <= divider_of(ctrl.output_divider_code);
      end
   end

endmodule // synth_ratio_decode

//--- hdl/synth_lock_timer.sv
module synth_lock_timer
   import pll_clock_pkg::*;
#(
   parameter int LOCK_COUNT = LOCK_CYCLES
)
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // run request and ratio settings
   input wire logic run,
   input wire logic [7:0] settings,
   // lock flag
   output logic synth_locked
);

   localparam int CW = $clog2(LOCK_COUNT + 1);
   localparam logic [CW-1:0] LAST = CW'(LOCK_COUNT - 1);

   generate
      if (LOCK_COUNT < 1) begin : g_bad_count
         $error("lock count must be at least one");
      end
   endgenerate

   synth_state_t state;
   logic [CW-1:0] count;
   logic [7:0] last_settings;
   logic changed;

   // a new ratio while running forces a fresh settle
   assign changed = (settings != last_settings);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_settings <= 8'h00;
      end else begin
         last_settings <= settings;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= SYNTH_OFF;
      end else begin
         case (state)
            SYNTH_OFF: if (run) state <= SYNTH_SETTLING;
            SYNTH_SETTLING: begin
               if (!run) state <= SYNTH_OFF;
               else if (!changed && count == LAST) state <= SYNTH_LOCKED;
            end
            SYNTH_LOCKED: begin
               if (!run) state <= SYNTH_OFF;
               else if (changed) state <= SYNTH_SETTLING;
            end
            default: state <= SYNTH_OFF;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= '0;
      end else if (state != SYNTH_SETTLING || changed || !run) begin
         count <= '0;
      end else if (count != LAST) begin
         count <= count + CW'(1);
      end
   end

   assign synth_locked = (state == SYNTH_LOCKED);

   lock_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !run |=> !synth_locked) else $error("lock flag stayed up after run dropped");

endmodule // synth_lock_timer

//--- hdl/pll_clock_synthesizer_control.sv
module pll_clock_synthesizer_control
   import pll_clock_pkg::*;
#(
   parameter int LOCK_COUNT = LOCK_CYCLES
)
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // oscillators and analog core clock
   input wire logic internal_oscillator,
   input wire logic external_oscillator,
   input wire logic oscillator_select,
   input wire logic pll_core_clock,
   // analog core control
   output logic core_reset_n,
   output logic core_enable,
   output logic core_predivide,
   output logic [5:0] core_multiplier,
   output logic [4:0] core_divider,
   // clocks out
   output logic synth_input_clock,
   output logic synth_output_clock,
   // state for observation
   output logic synth_locked
);

   generate
      if (LOCK_COUNT < 1) begin : g_bad_count
         $error("lock count must be at least one");
      end
   endgenerate

   pll_control_t ctrl;
   pll_control_t next_ctrl;
   pll_control_t read_view;
   logic addr_phase;
   logic addr_hit;
   logic wr_pending;
   logic code_valid;
   logic run;

   // the slave never stalls, so every data phase is one cycle
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // only whole-word accesses reach the register; others read zero
   assign addr_phase = hsel && hready && htrans[1];
   assign addr_hit = (haddr[31:2] == PLL_CONTROL_ADDR[31:2]) && (hsize == 3'h2);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pending <= 1'b0;
      end else begin
         wr_pending <= addr_phase && hwrite && addr_hit;
      end
   end

   // lock bit is never stored, so a write to it can do nothing
   always_comb begin
      next_ctrl = ctrl;
      if (wr_pending) begin
         next_ctrl = pll_control_t'(hwdata[15:0] & PLL_CONTROL_WRITE_MASK);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= pll_control_t'(PLL_CONTROL_RESET);
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // a read right behind a write sees the new value through next_ctrl
   always_comb begin
      read_view = next_ctrl;
      read_view.synth_locked = synth_locked;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         hrdata <= addr_hit ? {16'h0000, read_view} : 32'h0000_0000;
      end
   end

   // core reset and enable follow the stored bits directly
   assign core_reset_n = ctrl.reset_release;
   assign core_enable = ctrl.enable;

   // the synthesizer only counts as running once both bits are set and the multiplier code is available
   assign run = ctrl.reset_release && ctrl.enable && code_valid;

   synth_ratio_decode u_ratio (
      .hclk(hclk),
      .hresetn(hresetn),
      .ctrl(ctrl),
      .core_predivide(core_predivide),
      .core_multiplier(core_multiplier),
      .core_divider(core_divider),
      .code_valid(code_valid)
   );

   synth_lock_timer #(
      .LOCK_COUNT(LOCK_COUNT)
   ) u_lock (
      .hclk(hclk),
      .hresetn(hresetn),
      .run(run),
      .settings({ctrl.input_halver, ctrl.feedback_multiplier_code, ctrl.output_divider_code}),
      .synth_locked(synth_locked)
   );

   // plain muxes on clock nets; a glitch-free switch belongs in the clock cell library
   assign synth_input_clock = oscillator_select ? external_oscillator : internal_oscillator;
   assign synth_output_clock = ctrl.output_select ? pll_core_clock : synth_input_clock;

   reset_clear_a: assert property (@(posedge hclk)
      $rose(hresetn) |-> (ctrl == pll_control_t'(16'h0000)) && !core_reset_n && !core_enable && !synth_locked)
      else $error("control not cleared after reset");

   reset_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pending && !hwdata[RELEASE_BIT] |=> !core_reset_n ##1 !synth_locked)
      else $error("synthesizer reset not asserted by write");

   enable_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pending |=> core_enable == $past(hwdata[ENABLE_BIT]) && core_reset_n == $past(hwdata[RELEASE_BIT]))
      else $error("enable or release bit not taken");

   run_needs_both_a: assert property (@(posedge hclk) disable iff (!hresetn)
      synth_locked |-> $past(core_reset_n) && $past(core_enable))
      else $error("lock without release and enable");

   output_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pending |=> ctrl.output_select == $past(hwdata[OUTPUT_SELECT_BIT]))
      else $error("output select not taken");

   input_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
      synth_input_clock == (oscillator_select ? external_oscillator : internal_oscillator))
      else $error("wrong oscillator routed");

   divider_table_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pending |=> ##1 core_divider == divider_of($past(hwdata[2:0], 2)) &&
         core_predivide == $past(hwdata[HALVER_BIT], 2))
      else $error("divider or halver mismatch");

   multiplier_table_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pending |=> ##1 core_multiplier == multiplier_of($past(hwdata[7:4], 2)))
      else $error("multiplier mismatch");

   invalid_code_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !code_valid [*2] |-> !synth_locked)
      else $error("lock with unavailable multiplier code");

   lock_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      addr_phase && !hwrite && addr_hit |=> hrdata[LOCKED_BIT] == $past(synth_locked) && hrdata[31:16] == 16'h0000)
      else $error("lock bit read wrong");

   lock_reached_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(synth_locked));
   pll_routed_c: cover property (@(posedge hclk) disable iff (!hresetn) synth_locked && ctrl.output_select);
   bad_code_c: cover property (@(posedge hclk) disable iff (!hresetn) wr_pending && hwdata[7:6] == 2'h3);
   relock_c: cover property (@(posedge hclk) disable iff (!hresetn) $fell(synth_locked) && run);

endmodule // pll_clock_synthesizer_control

//--- verification/pll_clock_synthesizer_control_tb.sv
module pll_clock_synthesizer_control_tb;
   import pll_clock_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int LOCKN = 8;
   localparam int LIMIT = 20000;
   // release only, enable only, both with an unavailable multiplier code
   localparam logic [15:0] NOLOCK [3] = '{16'h8050, 16'h4050, 16'hc0c3};

   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic internal_oscillator, external_oscillator, oscillator_select, pll_core_clock;
   logic core_reset_n, core_enable, core_predivide, synth_input_clock, synth_output_clock, synth_locked;
   logic [5:0] core_multiplier;
   logic [4:0] core_divider;
   logic [31:0] lfsr = 32'h81848390;
   logic [31:0] rd;
   int errors, n_checks, cycles;

   assign hready = hreadyout;

   pll_clock_synthesizer_control #(.LOCK_COUNT(LOCKN)) pll_clock_synthesizer_control_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .internal_oscillator(internal_oscillator), .external_oscillator(external_oscillator),
      .oscillator_select(oscillator_select), .pll_core_clock(pll_core_clock), .core_reset_n(core_reset_n),
      .core_enable(core_enable), .core_predivide(core_predivide), .core_multiplier(core_multiplier),
      .core_divider(core_divider), .synth_input_clock(synth_input_clock),
      .synth_output_clock(synth_output_clock), .synth_locked(synth_locked));

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   function automatic logic [31:0] next_rand();
      lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c11db7 : 32'h0);
      return lfsr;
   endfunction

   function automatic logic [5:0] want_mult(input logic [3:0] c);
      logic [5:0] t [12] = '{6'h04, 6'h06, 6'h08, 6'h0a, 6'h0c, 6'h0e, 6'h10, 6'h12, 6'h14, 6'h18, 6'h1a, 6'h22};
      return (c < 4'hc) ? t[c] : 6'h00;
   endfunction

   function automatic logic [4:0] want_div(input logic [2:0] c);
      logic [4:0] t [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h03, 5'h10};
      return t[c];
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // a hang anywhere lands here rather than running forever
   always @(posedge hclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         errors++;
         summarize();
      end
   end

   task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= addr;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= HTRANS_IDLE;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
      check({31'h0, hresp}, 32'h0);
      check({31'h0, hreadyout}, 32'h1);
   endtask

   // write a value, then look at every output that follows from it except the lock flag
   task automatic apply(input logic [15:0] v);
      logic [31:0] r;
      logic [31:0] x;
      logic src;
      x = next_rand();
      bus(1'b1, PLL_CONTROL_ADDR, {x[31:16], v}, r);
      repeat (3) @(posedge hclk);
      #2;
      check({31'h0, core_reset_n}, {31'h0, v[15]});
      check({31'h0, core_enable}, {31'h0, v[14]});
      check({31'h0, core_predivide}, {31'h0, v[8]});
      check({26'h0, core_multiplier}, {26'h0, want_mult(v[7:4])});
      check({27'h0, core_divider}, {27'h0, want_div(v[2:0])});
      x = next_rand();
      {internal_oscillator, external_oscillator, oscillator_select, pll_core_clock} = x[3:0];
      #1;
      src = x[1] ? x[2] : x[3];
      check({31'h0, synth_input_clock}, {31'h0, src});
      check({31'h0, synth_output_clock}, {31'h0, v[13] ? x[0] : src});
      bus(1'b0, PLL_CONTROL_ADDR, 32'h0, r);
      check(r & 32'hffffefff, {16'h0, v & 16'he1f7});
   endtask

   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, internal_oscillator, external_oscillator, oscillator_select, pll_core_clock} = 6'h00;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = HTRANS_IDLE;
      hsize = 3'h2;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         #2;
         check({26'h0, core_reset_n, core_enable, core_predivide, synth_locked, 2'h0}, 32'h0);
         check({21'h0, core_multiplier, core_divider}, {21'h0, RESET_MULTIPLIER, RESET_DIVIDER});
         bus(1'b0, PLL_CONTROL_ADDR, 32'h0, rd);
         check(rd, {16'h0, PLL_CONTROL_RESET});
         apply(16'he1f7);
         // second reset mid-run must clear everything again
         @(posedge hclk);
         hresetn <= 1'b0;
         repeat (2) @(posedge hclk);
         hresetn <= 1'b1;
      end
      $display("test reset done");
      for (int i = 0; i < 16; i++) apply({8'h00, 4'(i), 1'b0, 3'(i)});
      apply(16'hffff);
      $display("test ratio tables done");
      for (int i = 0; i < 24; i++) begin
         rd = next_rand();
         apply(rd[15:0]);
      end
      $display("test random writes done");
      // unavailable multiplier code keeps the lock flag low for the readback below
      apply(16'hffff);
      bus(1'b1, PLL_CONTROL_ADDR + 32'h4, 32'h0000ffff, rd);
      bus(1'b0, PLL_CONTROL_ADDR + 32'h4, 32'h0, rd);
      check(rd, 32'h0);
      bus(1'b0, PLL_CONTROL_ADDR, 32'h0, rd);
      check(rd, 32'h0000e1f7);
      $display("test unmapped done");
      // run without release, without enable, or with an unavailable multiplier code never locks; both bits are needed
      for (int j = 0; j < 3; j++) begin
         apply(NOLOCK[j]);
         repeat (3 * LOCKN) @(posedge hclk);
         check({31'h0, synth_locked}, 32'h0);
      end
      apply(16'he0b5);
      check({31'h0, synth_locked}, 32'h0);
      for (int w = 0; w < 4 * LOCKN && synth_locked !== 1'b1; w++) @(posedge hclk);
      check({31'h0, synth_locked}, 32'h1);
      bus(1'b0, PLL_CONTROL_ADDR, 32'h0, rd);
      check(rd, 32'h0000f0b5);
      bus(1'b1, PLL_CONTROL_ADDR, 32'h000040b5, rd);
      repeat (3) @(posedge hclk);
      check({31'h0, synth_locked}, 32'h0);
      $display("test lock done");
      summarize();
   end
endmodule // pll_clock_synthesizer_control_tb
